/* hdl/gpcm_pkg.sv */
// Constants shared by the three-port pin configuration block
package gpcm_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int PORT_CNT = 3;
    localparam int PIN_CNT = 24;
    localparam logic [7:0] PORT_STRIDE = 8'h20;
    localparam logic [4:0] OFS_MODE_LOW = 5'h00;
    localparam logic [4:0] OFS_MODE_HIGH = 5'h04;
    localparam logic [4:0] OFS_INPUT_LEVEL = 5'h08;
    localparam logic [4:0] OFS_OUTPUT_LATCH = 5'h0c;
    localparam logic [4:0] OFS_OUTPUT_SET = 5'h10;
    localparam logic [4:0] OFS_OUTPUT_CLEAR = 5'h14;
    localparam logic [7:0] OFS_TIMER_ROUTE = 8'h60;
    localparam logic [7:0] OFS_DEBUG_CTRL = 8'h64;
    localparam logic [7:0] OFS_DEBUG_STATUS = 8'h68;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int TIMER_ROUTE_LSB = 4;
    localparam int DBGC_EXT_REG = 0;
    localparam int DBGC_DBG_OFF = 1;
    localparam int DBGC_TRACE_SEL = 2;
    localparam int DBGS_BOOT = 0;
    localparam int DBGS_JTAG = 1;
    localparam int DBGS_SWIRE = 2;
    localparam logic [2:0] DBGC_RESET = 3'h1;
    localparam logic [7:0] TIMER_ROUTE_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;

    // ****************************************
    // Pin indices of special functions
    // ****************************************
    localparam int PIN_A4 = 4;
    localparam int PIN_A5 = 5;
    localparam int PIN_A7 = 7;
    localparam int PIN_C0 = 16;
    localparam int PIN_C2 = 18;
    localparam int PIN_C3 = 19;
    localparam int PIN_C4 = 20;
    localparam int TIM_PIN_A [4] = '{0, 3, 1, 2};
    localparam int TIM_PIN_B [4] = '{9, 10, 11, 12};

    // ****************************************
    // Mode codes
    // ****************************************
    localparam logic [3:0] MODE_ANALOG = 4'h0;
    localparam logic [3:0] MODE_IN_FLOAT = 4'h4;
    localparam logic [3:0] MODE_IN_PULL = 4'h8;
    localparam logic [3:0] MODE_OUT_PP = 4'h1;
    localparam logic [3:0] MODE_OUT_OD = 4'h5;
    localparam logic [3:0] MODE_ALT_PP = 4'h9;
    localparam logic [3:0] MODE_ALT_OD = 4'hd;
    localparam logic [3:0] MODE_ALT_SCLK = 4'hb;
    localparam logic [3:0] MODE_RESET = MODE_IN_FLOAT;

    // ****************************************
    // Timing
    // ****************************************
    localparam int BOOT_RC_PERIODS = 512;
    localparam int FAST_RC_KHZ = 12000;
    localparam int CLK_KHZ = 100000;
    localparam int BOOT_DELAY_CYC =
        (BOOT_RC_PERIODS * CLK_KHZ + FAST_RC_KHZ - 1) / FAST_RC_KHZ;
endpackage

/* hdl/gpcm_top.sv */
// Three 8-pin ports: mode decode, latch, input sampling, forcing, boot pin
// ****************************************
// ****************************************
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module gpcm_top #(
    parameter int BOOT_DELAY_CYCLES = gpcm_pkg::BOOT_DELAY_CYC,
    parameter logic [23:0] ASSOC_MASK = 24'hffffff
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic boot_reset_kind_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pads
    input wire logic [gpcm_pkg::PIN_CNT-1:0] pad_in_i,
    output logic [gpcm_pkg::PIN_CNT-1:0] pad_out_o,
    output logic [gpcm_pkg::PIN_CNT-1:0] pad_oe_o,
    output logic [gpcm_pkg::PIN_CNT-1:0] pad_pull_up_o,
    output logic [gpcm_pkg::PIN_CNT-1:0] pad_pull_down_o,
    output logic [gpcm_pkg::PIN_CNT-1:0] pad_analog_o,
    // Peripheral side
    input wire logic [gpcm_pkg::PIN_CNT-1:0] periph_alt_i,
    input wire logic [3:0] timer_b_ch_i,
    input wire logic [3:0] timer_b_output_enable_i,
    input wire logic packet_trace_enable_i,
    input wire logic packet_trace_data_i,
    input wire logic cpu_trace_bit2_i,
    input wire logic cpu_trace_bit3_i,
    input wire logic regulator_enable_i,
    output logic [gpcm_pkg::PIN_CNT-1:0] periph_in_o,
    // Debugger
    input wire logic dbg_jtag_active_i,
    input wire logic dbg_swire_active_i,
    input wire logic jtag_data_out_i,
    input wire logic swire_drive_i,
    input wire logic swire_data_out_i,
    output logic boot_select_captured_o
);
    import gpcm_pkg::*;

    logic [3:0] mode_r [PIN_CNT];
    logic [PIN_CNT-1:0] latch_r;
    logic [7:0] route_r;
    logic [2:0] dbgc_r;
    logic [PIN_CNT-1:0] sync1_r, sync2_r, sync3_r, level_r;
    logic [PIN_CNT-1:0] in_level_r;
    logic boot_busy_r;
    logic boot_cap_r;
    logic [15:0] boot_cnt_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [PIN_CNT-1:0] out_nxt, oe_nxt, pu_nxt, pd_nxt, ana_nxt;
    logic [PIN_CNT-1:0] out_r, oe_r, pu_r, pd_r, ana_r;
    logic wr_go, rd_go;
    logic [1:0] port_sel;
    logic [4:0] reg_sel;
    logic port_hit;
    logic dbg_on;

    // ****************************************
    // Bus decode
    // ****************************************
    // Requests are taken once; ack_r blocks a repeat in the ack cycle
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
    assign rd_go = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;
    assign port_sel = wb_adr_i[6:5];
    assign reg_sel = wb_adr_i[4:0];
    assign port_hit = ~wb_adr_i[7] & (port_sel != 2'd3);
    assign dbg_on = ~dbgc_r[DBGC_DBG_OFF];

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
        end
    end

    // ****************************************
    // Mode registers
    // ****************************************
    // Byte lanes 0 and 1 each hold two pin fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < PIN_CNT; p++) begin
                mode_r[p] <= MODE_RESET;
            end
        end else if (wr_go && port_hit) begin
            for (int f = 0; f < 4; f++) begin
                if (wb_sel_i[f/2] && reg_sel == OFS_MODE_LOW) begin
                    mode_r[port_sel*8+f] <= wb_dat_i[f*4 +: 4];
                end
                if (wb_sel_i[f/2] && reg_sel == OFS_MODE_HIGH) begin
                    mode_r[port_sel*8+4+f] <= wb_dat_i[f*4 +: 4];
                end
            end
        end
    end

    // Latch: direct write, or set / clear strobes with zeros ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_r <= {PORT_CNT{LATCH_RESET}};
        end else if (wr_go && port_hit && wb_sel_i[0]) begin
            case (reg_sel)
                OFS_OUTPUT_LATCH: begin
                    latch_r[port_sel*8 +: 8] <= wb_dat_i[7:0];
                end
                OFS_OUTPUT_SET: begin
                    latch_r[port_sel*8 +: 8] <=
                        latch_r[port_sel*8 +: 8] | wb_dat_i[7:0];
                end
                OFS_OUTPUT_CLEAR: begin
                    latch_r[port_sel*8 +: 8] <=
                        latch_r[port_sel*8 +: 8] & ~wb_dat_i[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Timer route option and debug control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_r <= TIMER_ROUTE_RESET;
            dbgc_r <= DBGC_RESET;
        end else if (wr_go && wb_sel_i[0]) begin
            if (wb_adr_i == OFS_TIMER_ROUTE) begin
                route_r <= wb_dat_i[7:0];
            end
            if (wb_adr_i == OFS_DEBUG_CTRL) begin
                dbgc_r <= wb_dat_i[2:0];
            end
        end
    end

    // Read data; unmapped and write-only offsets return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (rd_go) begin
            dat_r <= 32'h0000_0000;
            if (port_hit) begin
                case (reg_sel)
                    OFS_MODE_LOW: begin
                        for (int f = 0; f < 4; f++) begin
                            dat_r[f*4 +: 4] <= mode_r[port_sel*8+f];
                        end
                    end
                    OFS_MODE_HIGH: begin
                        for (int f = 0; f < 4; f++) begin
                            dat_r[f*4 +: 4] <= mode_r[port_sel*8+4+f];
                        end
                    end
                    OFS_INPUT_LEVEL: begin
                        dat_r[7:0] <= in_level_r[port_sel*8 +: 8];
                    end
                    OFS_OUTPUT_LATCH: begin
                        dat_r[7:0] <= latch_r[port_sel*8 +: 8];
                    end
                    default: begin
                    end
                endcase
            end else if (wb_adr_i == OFS_TIMER_ROUTE) begin
                dat_r[7:0] <= route_r;
            end else if (wb_adr_i == OFS_DEBUG_CTRL) begin
                dat_r[2:0] <= dbgc_r;
            end else if (wb_adr_i == OFS_DEBUG_STATUS) begin
                dat_r[DBGS_BOOT] <= boot_cap_r;
                dat_r[DBGS_JTAG] <= dbg_on & dbg_jtag_active_i;
                dat_r[DBGS_SWIRE] <= dbg_on & dbg_swire_active_i;
            end
        end
    end

    // ****************************************
    // Input sampling
    // ****************************************
    // Three stages; a new level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        sync1_r <= pad_in_i;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        level_r <= (sync2_r & sync3_r) | (level_r & (sync2_r | sync3_r));
    end

    // Analog pins read high; sampling runs always, even for outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_level_r <= '0;
        end else begin
            in_level_r <= level_r | ana_r;
        end
    end

    // ****************************************
    // Boot select pin
    // ****************************************
    // Only pin and always-on power resets open the sampling window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_busy_r <= boot_reset_kind_i;
            boot_cnt_r <= 16'h0000;
        end else if (boot_busy_r) begin
            boot_cnt_r <= boot_cnt_r + 16'h0001;
            if (boot_cnt_r == 16'(BOOT_DELAY_CYCLES - 1)) begin
                boot_busy_r <= 1'b0;
            end
        end
    end

    // Captured level survives resets that do not sample it
    always_ff @(posedge clk_i) begin
        if (rst_i && boot_reset_kind_i) begin
            boot_cap_r <= 1'b1;
        end else if (!rst_i && boot_busy_r &&
                     boot_cnt_r == 16'(BOOT_DELAY_CYCLES - 1)) begin
            boot_cap_r <= level_r[PIN_A5];
        end
    end

    // ****************************************
    // Pin function decode
    // ****************************************
    always_comb begin
        logic [PIN_CNT-1:0] alt;
        logic m_od;
        alt = periph_alt_i & ASSOC_MASK;
        m_od = 1'b0;
        // Enabled timer channels override serial outputs on shared pins
        for (int c = 0; c < 4; c++) begin
            if (timer_b_output_enable_i[c]) begin
                if (route_r[TIMER_ROUTE_LSB+c]) begin
                    alt[TIM_PIN_B[c]] = timer_b_ch_i[c];
                end else begin
                    alt[TIM_PIN_A[c]] = timer_b_ch_i[c];
                end
            end
        end
        alt[PIN_A4] = dbgc_r[DBGC_TRACE_SEL] ? cpu_trace_bit2_i
                                             : packet_trace_enable_i;
        alt[PIN_A5] = dbgc_r[DBGC_TRACE_SEL] ? cpu_trace_bit3_i
                                             : packet_trace_data_i;
        out_nxt = '0;
        oe_nxt = '0;
        pu_nxt = '0;
        pd_nxt = '0;
        ana_nxt = '0;
        for (int p = 0; p < PIN_CNT; p++) begin
            case (mode_r[p])
                MODE_ANALOG: begin
                    ana_nxt[p] = 1'b1;
                end
                MODE_IN_PULL: begin
                    pu_nxt[p] = latch_r[p];
                    pd_nxt[p] = ~latch_r[p];
                end
                MODE_OUT_PP: begin
                    oe_nxt[p] = 1'b1;
                    out_nxt[p] = latch_r[p];
                end
                MODE_OUT_OD: begin
                    oe_nxt[p] = ~latch_r[p];
                end
                MODE_ALT_PP, MODE_ALT_SCLK: begin
                    oe_nxt[p] = 1'b1;
                    out_nxt[p] = alt[p];
                end
                MODE_ALT_OD: begin
                    oe_nxt[p] = ~alt[p];
                end
                default: begin
                    // Floating input; reserved codes behave the same
                end
            endcase
        end
        // Boot window: pulled-up input regardless of mode
        if (boot_busy_r) begin
            oe_nxt[PIN_A5] = 1'b0;
            out_nxt[PIN_A5] = 1'b0;
            pu_nxt[PIN_A5] = 1'b1;
            pd_nxt[PIN_A5] = 1'b0;
            ana_nxt[PIN_A5] = 1'b0;
        end
        // Regulator enable as open-drain on A7
        if (dbgc_r[DBGC_EXT_REG]) begin
            m_od = ~regulator_enable_i;
            oe_nxt[PIN_A7] = m_od;
            out_nxt[PIN_A7] = 1'b0;
            pu_nxt[PIN_A7] = 1'b0;
            pd_nxt[PIN_A7] = 1'b0;
            ana_nxt[PIN_A7] = 1'b0;
        end
        // JTAG pins, unless the debugger is switched off
        if (dbg_on && dbg_jtag_active_i) begin
            oe_nxt[PIN_C0] = 1'b0;
            oe_nxt[PIN_C3] = 1'b0;
            oe_nxt[PIN_C4] = 1'b0;
            pu_nxt[PIN_C0] = 1'b1;
            pu_nxt[PIN_C3] = 1'b1;
            pu_nxt[PIN_C4] = 1'b1;
            pd_nxt[PIN_C0] = 1'b0;
            pd_nxt[PIN_C3] = 1'b0;
            pd_nxt[PIN_C4] = 1'b0;
            ana_nxt[PIN_C0] = 1'b0;
            ana_nxt[PIN_C3] = 1'b0;
            ana_nxt[PIN_C4] = 1'b0;
            oe_nxt[PIN_C2] = 1'b1;
            out_nxt[PIN_C2] = jtag_data_out_i;
            pu_nxt[PIN_C2] = 1'b0;
            pd_nxt[PIN_C2] = 1'b0;
            ana_nxt[PIN_C2] = 1'b0;
        end else if (dbg_on && dbg_swire_active_i) begin
            oe_nxt[PIN_C4] = swire_drive_i;
            out_nxt[PIN_C4] = swire_data_out_i;
            pu_nxt[PIN_C4] = 1'b0;
            pd_nxt[PIN_C4] = 1'b0;
            ana_nxt[PIN_C4] = 1'b0;
        end
    end

    // ****************************************
    // Registered pad controls
    // ****************************************
    // Pull-up on A5 is already on while a boot-sampling reset is held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_r <= '0;
            oe_r <= '0;
            pd_r <= '0;
            ana_r <= '0;
            pu_r <= '0;
            pu_r[PIN_A5] <= boot_reset_kind_i;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            pu_r <= pu_nxt;
            pd_r <= pd_nxt;
            ana_r <= ana_nxt;
        end
    end

    assign pad_out_o = out_r;
    assign pad_oe_o = oe_r;
    assign pad_pull_up_o = pu_r;
    assign pad_pull_down_o = pd_r;
    assign pad_analog_o = ana_r;
    assign periph_in_o = in_level_r;
    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign boot_select_captured_o = boot_cap_r;
endmodule

/* dv/gpcm_board.sv */
// Board model: resolves every pad level from all drivers and pulls
`timescale 1ns/1ps
module gpcm_board (
    // Clock
    input wire logic clk_i,
    // Device pad drive
    input wire logic [23:0] pad_out_i,
    input wire logic [23:0] pad_oe_i,
    input wire logic [23:0] pull_up_i,
    input wire logic [23:0] pull_down_i,
    // Board drive commanded by the bench
    input wire logic [23:0] ext_en_i,
    input wire logic [23:0] ext_val_i,
    // Resolved level
    output logic [23:0] level_o
);
    logic [23:0] float_r = 24'h000000;
    // Unheld pins wander; never trust a stale level
    always_ff @(posedge clk_i) begin
        float_r <= ~float_r;
    end
    // Device driver first, then board driver, then the pulls
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (pad_oe_i[i]) level_o[i] = pad_out_i[i];
            else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
            else if (pull_up_i[i]) level_o[i] = 1'b1;
            else if (pull_down_i[i]) level_o[i] = 1'b0;
            else level_o[i] = float_r[i];
        end
    end
endmodule

/* dv/gpcm_top_chk.sv */
// Concurrent checks on the pin configuration block's ports
`timescale 1ns/1ps
module gpcm_top_chk #(
    parameter int BOOT_DELAY_CYCLES = gpcm_pkg::BOOT_DELAY_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic boot_reset_kind_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Pads and peripheral side
    input wire logic [gpcm_pkg::PIN_CNT-1:0] pad_in_i,
    input wire logic [gpcm_pkg::PIN_CNT-1:0] pad_out_o,
    input wire logic [gpcm_pkg::PIN_CNT-1:0] pad_oe_o,
    input wire logic [gpcm_pkg::PIN_CNT-1:0] pad_pull_up_o,
    input wire logic [gpcm_pkg::PIN_CNT-1:0] pad_pull_down_o,
    input wire logic [gpcm_pkg::PIN_CNT-1:0] pad_analog_o,
    input wire logic [gpcm_pkg::PIN_CNT-1:0] periph_in_o,
    input wire logic regulator_enable_i,
    input wire logic dbg_jtag_active_i,
    input wire logic jtag_data_out_i
);
    import gpcm_pkg::*;
    logic ext_r, off_r, win_r;
    int unsigned cnt_r;
    // Debug control shadow, taken at the request edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_r <= 1'b1;
            off_r <= 1'b0;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                     wb_adr_i == OFS_DEBUG_CTRL && wb_sel_i[0]) begin
            ext_r <= wb_dat_i[DBGC_EXT_REG];
            off_r <= wb_dat_i[DBGC_DBG_OFF];
        end
    end
    // Cycles since a boot-kind reset ended
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_r <= boot_reset_kind_i;
            cnt_r <= 0;
        end else if (win_r) begin
            cnt_r <= cnt_r + 1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // Assertions
    // ****************************************
    AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack long");
    AST_PULL_EXCL: assert property ((pad_pull_up_o & pad_pull_down_o) == '0)
        else $error("two pulls");
    AST_PULL_NO_DRIVE: assert property (((pad_pull_up_o | pad_pull_down_o) & pad_oe_o) == '0)
        else $error("pull drives");
    AST_ANALOG_QUIET: assert property ((pad_analog_o & (pad_oe_o | pad_pull_up_o | pad_pull_down_o)) == '0)
        else $error("analog busy");
    AST_ANALOG_ONE: assert property (pad_analog_o[9] [*8] |-> periph_in_o[9])
        else $error("analog low");
    AST_IN_FOLLOW: assert property ((!pad_analog_o[8] && $stable(pad_in_i[8])) [*8] |-> periph_in_o[8] == pad_in_i[8])
        else $error("input lag");
    AST_REG_A7: assert property ($past(ext_r) && !$past(rst_i) |-> pad_oe_o[7] == !$past(regulator_enable_i) && !pad_out_o[7])
        else $error("A7 forcing");
    AST_JTAG_C2: assert property ($past(dbg_jtag_active_i) && !$past(off_r) && !$past(rst_i) |-> pad_oe_o[18] && pad_out_o[18] == $past(jtag_data_out_i) && pad_pull_up_o[16])
        else $error("C2 forcing");
    AST_BOOT_PULL: assert property (win_r && cnt_r >= 1 && cnt_r + 2 <= BOOT_DELAY_CYCLES |-> pad_pull_up_o[5] && !pad_oe_o[5])
        else $error("boot pull");
    COV_JTAG: cover property (dbg_jtag_active_i && !off_r);
    COV_BOOT: cover property (win_r && cnt_r == 2);
    COV_WRITE: cover property (wb_ack_o && wb_we_i);
endmodule
bind gpcm_top gpcm_top_chk
    #(.BOOT_DELAY_CYCLES(BOOT_DELAY_CYCLES)) chk_u (.*);

/* dv/gpio_port_config_mux_tb.sv */
// Self-checking bench: pin modes, latch strobes, overrides and boot pin
`timescale 1ns/1ps
module gpio_port_config_mux_tb;
    import gpcm_pkg::*;
    logic clk_i, ack, boot;
    logic rst_i = 1'b1, kind = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0;
    logic wb_we = 1'b0, pte = 1'b0, ct2 = 1'b0, ren = 1'b0, jt = 1'b0;
    logic jdo = 1'b0, sw = 1'b0, swd = 1'b0, swo = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0, dat_o, rd;
    logic [23:0] alt = 24'h0, ext_en = 24'h000020, ext_val = 24'h0;
    logic [23:0] pad_in, out, oe, pu, pd, an, per;
    logic [3:0] tch = 4'h0, ten = 4'h0;
    int miscompares = 0, checks = 0;
    logic [3:0] codes [8] = '{MODE_ANALOG, MODE_IN_FLOAT, MODE_IN_PULL,
        MODE_OUT_PP, MODE_OUT_OD, MODE_ALT_PP, MODE_ALT_OD, MODE_ALT_SCLK};
    // Small boot window keeps the run short; pin A0 has no peripheral
    gpcm_top #(.BOOT_DELAY_CYCLES(8), .ASSOC_MASK(24'hfffffe)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .boot_reset_kind_i(kind),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .pad_in_i(pad_in),
        .pad_out_o(out), .pad_oe_o(oe), .pad_pull_up_o(pu),
        .pad_pull_down_o(pd), .pad_analog_o(an), .periph_alt_i(alt),
        .timer_b_ch_i(tch), .timer_b_output_enable_i(ten),
        .packet_trace_enable_i(pte), .packet_trace_data_i(1'b0),
        .cpu_trace_bit2_i(ct2), .cpu_trace_bit3_i(1'b0),
        .regulator_enable_i(ren), .periph_in_o(per),
        .dbg_jtag_active_i(jt), .dbg_swire_active_i(sw),
        .jtag_data_out_i(jdo), .swire_drive_i(swd),
        .swire_data_out_i(swo), .boot_select_captured_o(boot));
    gpcm_board brd_u (.clk_i(clk_i), .pad_out_i(out), .pad_oe_i(oe),
        .pull_up_i(pu), .pull_down_i(pd), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .level_o(pad_in));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Classic cycle; entered just after a rising edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_o;
        if (n >= 50) miscompares++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask
    // Fields: analog, pull up, pull down, enable, driven high
    task automatic pchk(input string what, input int p,
                        input logic [4:0] exp);
        repeat (2) @(posedge clk_i);
        check(what, {27'h0, an[p], pu[p], pd[p], oe[p], oe[p] & out[p]},
              {27'h0, exp});
    endtask
    task automatic do_reset(input logic k);
        rst_i <= 1'b1;
        kind <= k;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    function automatic logic [7:0] pa(input logic [1:0] p,
                                      input logic [4:0] o);
        return {1'b0, p, o};
    endfunction
    function automatic logic [4:0] pin_exp(input logic [3:0] m,
                                           input logic l, input logic a);
        case (m)
            MODE_ANALOG: return 5'h10;
            MODE_IN_PULL: return {1'b0, l, !l, 2'b00};
            MODE_OUT_PP: return {3'b000, 1'b1, l};
            MODE_OUT_OD: return {3'b000, !l, 1'b0};
            MODE_ALT_PP, MODE_ALT_SCLK: return {3'b000, 1'b1, a};
            MODE_ALT_OD: return {3'b000, !a, 1'b0};
            default: return 5'h00;
        endcase
    endfunction
    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // Clock, watchdog and test sequence
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Whole sequence needs about three hundred cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        results();
    end
    initial begin
        do_reset(1'b1);
        check("boot pull", pu[5], 1'b1);
        repeat (20) @(posedge clk_i);
        check("boot pull off", pu[5], 1'b0);
        rchk("status", OFS_DEBUG_STATUS, 32'h0);
        ext_val[5] <= 1'b1;
        rchk("mode low A", pa(0, OFS_MODE_LOW), 32'h4444);
        rchk("mode high C", pa(2, OFS_MODE_HIGH), 32'h4444);
        rchk("debug ctrl", OFS_DEBUG_CTRL, 32'h1);
        rchk("latch", pa(1, OFS_OUTPUT_LATCH), 32'h0);
        rchk("unmapped", 8'h7c, 32'h0);
        wb(1'b1, pa(1, OFS_OUTPUT_LATCH), 32'h0f);
        wb(1'b1, pa(1, OFS_OUTPUT_SET), 32'h30);
        rchk("latch set", pa(1, OFS_OUTPUT_LATCH), 32'h3f);
        wb(1'b1, pa(1, OFS_OUTPUT_CLEAR), 32'h05);
        rchk("latch clr", pa(1, OFS_OUTPUT_LATCH), 32'h3a);
        rchk("set reg", pa(1, OFS_OUTPUT_SET), 32'h0);
        for (int p = 0; p < 2; p++) begin
            wb(1'b1, pa(1, p ? OFS_OUTPUT_SET : OFS_OUTPUT_CLEAR), 32'h1);
            alt[8] <= !p[0];
            for (int i = 0; i < 8; i++) begin
                wb(1'b1, pa(1, OFS_MODE_LOW), {28'h0, codes[i]});
                pchk("pin B0", 8, pin_exp(codes[i], p[0], !p[0]));
            end
        end
        wb(1'b1, pa(1, OFS_MODE_LOW), 32'h4);
        ext_en[8] <= 1'b1;
        for (int v = 0; v < 2; v++) begin
            ext_val[8] <= v[0];
            repeat (8) @(posedge clk_i);
            wb(1'b0, pa(1, OFS_INPUT_LEVEL), 32'h0);
            check("in B0", rd[0], v[0]);
            check("periph B0", per[8], v[0]);
        end
        wb(1'b1, pa(1, OFS_MODE_LOW), 32'h0);
        repeat (8) @(posedge clk_i);
        wb(1'b0, pa(1, OFS_INPUT_LEVEL), 32'h0);
        check("analog B0", rd[0], 1'b1);
        ext_en[8] <= 1'b0;
        alt[0] <= 1'b1;
        wb(1'b1, pa(0, OFS_MODE_LOW), 32'h9);
        pchk("no periph A0", 0, 5'h02);
        wb(1'b1, OFS_TIMER_ROUTE, 32'h10);
        wb(1'b1, pa(1, OFS_MODE_LOW), 32'h90);
        alt[9] <= 1'b1;
        ten <= 4'h1;
        pchk("timer B1", 9, 5'h02);
        ten <= 4'h0;
        pchk("serial B1", 9, 5'h03);
        pte <= 1'b1;
        wb(1'b1, pa(0, OFS_MODE_HIGH), 32'h9);
        pchk("packet A4", 4, 5'h03);
        wb(1'b1, OFS_DEBUG_CTRL, 32'h5);
        pchk("cpu trace A4", 4, 5'h02);
        pchk("reg sink A7", 7, 5'h02);
        ren <= 1'b1;
        pchk("reg free A7", 7, 5'h00);
        wb(1'b1, OFS_DEBUG_CTRL, 32'h0);
        pchk("plain A7", 7, 5'h10);
        jt <= 1'b1;
        jdo <= 1'b1;
        pchk("jtag C2", 18, 5'h03);
        pchk("jtag C0", 16, 5'h08);
        wb(1'b1, OFS_DEBUG_CTRL, 32'h2);
        pchk("off C2", 18, 5'h00);
        wb(1'b1, OFS_DEBUG_CTRL, 32'h0);
        jt <= 1'b0;
        sw <= 1'b1;
        swd <= 1'b1;
        swo <= 1'b1;
        pchk("wire out C4", 20, 5'h03);
        swd <= 1'b0;
        pchk("wire in C4", 20, 5'h00);
        sw <= 1'b0;
        do_reset(1'b0);
        check("no boot pull", pu[5], 1'b0);
        rchk("status kept", OFS_DEBUG_STATUS, 32'h0);
        rchk("mode reset", pa(1, OFS_MODE_LOW), 32'h4444);
        rchk("ctrl reset", OFS_DEBUG_CTRL, 32'h1);
        do_reset(1'b1);
        repeat (20) @(posedge clk_i);
        rchk("status high", OFS_DEBUG_STATUS, 32'h1);
        check("boot pin", boot, 1'b1);
        results();
    end
endmodule
